// [hdl/uhc_consts.vh]
`ifndef UHC_CONSTS_VH
`define UHC_CONSTS_VH
// Interrupt pulse length in milliseconds and in 100 ns clock cycles.
`define UHC_INT_PULSE_MS 2400
`define UHC_CLK_HZ 10000000
`define UHC_INT_PULSE_CYC ((`UHC_INT_PULSE_MS * (`UHC_CLK_HZ / 1000)))
// Load-sense debounce time in microseconds and cycles.
`define UHC_ATTACH_US 100
`define UHC_ATTACH_CYC ((`UHC_ATTACH_US * (`UHC_CLK_HZ / 1000000)))
// Anti-loop hold-off after a detach in milliseconds and cycles.
`define UHC_HOLDOFF_MS 1000
`define UHC_HOLDOFF_CYC ((`UHC_HOLDOFF_MS * (`UHC_CLK_HZ / 1000)))
// Signature codes presented on the connector in dedicated charging.
`define UHC_SIG_NONE 2'h0
`define UHC_SIG_BC 2'h1
`define UHC_SIG_VENDOR 2'h2
// Port roles reported on the mode output.
`define UHC_ROLE_IDLE 3'h0
`define UHC_ROLE_DCP 3'h1
`define UHC_ROLE_PASS 3'h2
`define UHC_ROLE_SDP 3'h3
`define UHC_ROLE_CDP 3'h4
`endif

// [hdl/uhc_ctrl.v]
// Overview of operation
// R1: Active-high variant drives interrupt high 2.4 s.
// R2: Active-low variant pulls interrupt low 2.4 s.
// R3: Awake select low gives auto dedicated charging.
// R4: Awake high, type low gives SDP only.
// R5: Both high gives CDP or SDP.
// R6: Sense load first, then pick charging mode.
// R7: On S0 to S3, keep mouse/keyboard connection.
// R8: BC dedicated mode shorts D+ to D-.
// R9: Choose BC or vendor signature per device.
// R10: CDP runs primary and secondary detection, data allowed.
// R11: System powers up with select mid-level for manual DCP; not detected here, as the select arrives as a clean logic level.
// R12: Anti-loop hold-off stops HDD power cycling.
// R13: Each edge restarts a full interrupt period.
`timescale 1ns/10ps
`include "uhc_consts.vh"

module uhc_ctrl #(
  parameter INT_ACTIVE_HIGH = 1,
  parameter [31:0] INT_PULSE_CYC = `UHC_INT_PULSE_CYC,
  parameter [31:0] HOLDOFF_CYC = `UHC_HOLDOFF_CYC
) (
  input wire clk,
  input wire reset,
  input wire system_awake_sel,
  input wire charge_type_sel,
  input wire load_sensed,
  input wire dev_low_full_speed,
  input wire dev_hid_class,
  input wire dev_vendor_sig,
  input wire dev_cdp_request,
  input wire primary_det_done,
  input wire secondary_det_done,
  output reg int_out,
  output reg int_oe,
  output reg host_path_en,
  output reg dp_dm_short,
  output reg [1:0] dcp_signature,
  output reg cdp_primary_en,
  output reg cdp_secondary_en,
  output reg [2:0] port_role
);

  // Attach states, binary coded.
  localparam ST_IDLE = 3'h0;
  localparam ST_DEBOUNCE = 3'h1;
  localparam ST_IDENT = 3'h2;
  localparam ST_CHARGE = 3'h3;
  localparam ST_HOLDOFF = 3'h4;

  // Debounce length for a newly sensed load.
  localparam [31:0] ATTACH_CYC = `UHC_ATTACH_CYC;

  //////////////////////////////////////////////////////////////////////////////
  // Shared arithmetic and decoding.

  // One step of a down counter that parks at zero instead of wrapping.
  function [31:0] uhc_count_down;
    input [31:0] value;
    begin
      if (value != 32'h0) begin
        uhc_count_down = value - 32'h1;
      end else begin
        uhc_count_down = 32'h0;
      end
    end
  endfunction

  // The pulse stays up while more than one count remains, which with the
  // registered enable gives exactly the loaded number of cycles.
  function uhc_pulse_live;
    input [31:0] value;
    begin
      uhc_pulse_live = (value > 32'h1);
    end
  endfunction

  // Signature for a dedicated charger; only the BC form needs the short.
  function [1:0] uhc_sig_for;
    input is_vendor;
    begin
      if (is_vendor) begin
        uhc_sig_for = `UHC_SIG_VENDOR;
      end else begin
        uhc_sig_for = `UHC_SIG_BC;
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Input history for edge detection. The history resets to the sleep level,
  // so a block released from reset while awake sees one edge and raises the
  // interrupt once; the system can read that as a state report.
  reg awake_q;
  reg [31:0] int_cnt;
  reg [31:0] next_int_cnt;
  wire awake_edge = awake_q ^ system_awake_sel;
  wire awake_fall = awake_q & ~system_awake_sel;

  always @(posedge clk) begin
    if (reset) begin
      awake_q <= 1'b0;
    end else begin
      awake_q <= system_awake_sel;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt timer; an edge reloads it so back-to-back edges stretch the pulse.
  // R13: restart on edge
  always @* begin
    if (awake_edge) begin
      next_int_cnt = INT_PULSE_CYC;
    end else begin
      next_int_cnt = uhc_count_down(int_cnt);
    end
  end

  // The count is cleared in reset so a pulse never survives a reset.
  always @(posedge clk) begin
    if (reset) begin
      int_cnt <= 32'h0;
    end else begin
      int_cnt <= next_int_cnt;
    end
  end

  // The pin is open source or open drain, so it is only ever driven active.
  // The enable follows the count rather than the level, so the variants differ
  // only in the driven level; the board fits the pull that suits the variant.
  // R1: drive high pulse
  // R2: pull low pulse
  always @(posedge clk) begin
    if (reset) begin
      int_oe <= 1'b0;
      int_out <= 1'b0;
    end else begin
      int_oe <= awake_edge | uhc_pulse_live(int_cnt);
      int_out <= (INT_ACTIVE_HIGH != 0) ? 1'b1 : 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Attach state machine for the sleep-mode charger.
  // Idle waits for load, debounce filters contact bounce, identify samples
  // the device class for one cycle, charge holds until the load goes away,
  // and hold-off keeps the port quiet so a drive that browns out while
  // spinning up is not caught in an endless power cycle.
  // The timer is shared by debounce and hold-off; only one runs at a time.
  // Leaving sleep forces idle, since the awake modes need no attach sequence.
  // State, shared timer, and what identify learned about the device.
  reg [2:0] state;
  reg [2:0] next_state;
  reg [31:0] timer;
  reg [31:0] next_timer;
  reg passthru;
  reg next_passthru;
  reg vendor;
  reg next_vendor;

  // Sleep selects the automatic charger.
  wire auto_mode = ~system_awake_sel;

  // R6: sense then select
  // R12: hold-off after detach
  always @* begin
    next_state = state;
    next_timer = uhc_count_down(timer);
    next_passthru = passthru;
    next_vendor = vendor;
    case (state)
      ST_IDLE: begin
        next_passthru = 1'b0;
        if (load_sensed) begin
          next_state = ST_DEBOUNCE;
          next_timer = ATTACH_CYC;
        end
      end
      ST_DEBOUNCE: begin
        if (!load_sensed) begin
          next_state = ST_IDLE;
        end else if (timer == 32'h0) begin
          next_state = ST_IDENT;
        end
      end
      ST_IDENT: begin
        // R7: keep HID link
        next_passthru = dev_low_full_speed & dev_hid_class;
        // R9: pick signature
        next_vendor = dev_vendor_sig;
        next_state = ST_CHARGE;
      end
      ST_CHARGE: begin
        if (!load_sensed) begin
          next_state = ST_HOLDOFF;
          next_timer = HOLDOFF_CYC;
        end
      end
      ST_HOLDOFF: begin
        // A drive that drops its load while spinning up is not re-powered at once.
        if (timer == 32'h0) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // Re-identify on entry to sleep so a HID device keeps its host link.
    if (awake_fall && load_sensed && state != ST_HOLDOFF) begin
      next_state = ST_IDENT;
    end
    if (!auto_mode) begin
      next_state = ST_IDLE;
      next_passthru = 1'b0;
    end
  end

  // State registers; reset parks the port idle with no device known.
  always @(posedge clk) begin
    if (reset) begin
      state <= ST_IDLE;
      timer <= 32'h0;
      passthru <= 1'b0;
      vendor <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      passthru <= next_passthru;
      vendor <= next_vendor;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output routing per selected mode, decoded first and registered below so
  // that the switch controls never glitch on a select change.
  reg next_host_path_en;
  reg next_dp_dm_short;
  reg [1:0] next_dcp_signature;
  reg next_cdp_primary_en;
  reg next_cdp_secondary_en;
  reg [2:0] next_port_role;

  always @* begin
    next_host_path_en = 1'b0;
    next_dp_dm_short = 1'b0;
    next_dcp_signature = `UHC_SIG_NONE;
    next_cdp_primary_en = 1'b0;
    next_cdp_secondary_en = 1'b0;
    next_port_role = `UHC_ROLE_IDLE;
    if (auto_mode) begin
      // R3: auto dedicated mode
      if (state == ST_CHARGE && passthru) begin
        // R7: host link kept
        next_host_path_en = 1'b1;
        next_port_role = `UHC_ROLE_PASS;
      end else if (state == ST_CHARGE) begin
        // R8: short, no data
        next_dp_dm_short = ~vendor;
        // R9: signature per device
        next_dcp_signature = uhc_sig_for(vendor);
        next_port_role = `UHC_ROLE_DCP;
      end
    end else if (!charge_type_sel) begin
      // R4: SDP only
      next_host_path_en = 1'b1;
      next_port_role = `UHC_ROLE_SDP;
    end else begin
      // R5: CDP or SDP
      next_host_path_en = 1'b1;
      // R10: both detection phases
      if (dev_cdp_request) begin
        // Primary runs first; secondary opens only once primary is done.
        next_cdp_primary_en = ~primary_det_done;
        next_cdp_secondary_en = primary_det_done & ~secondary_det_done;
        next_port_role = `UHC_ROLE_CDP;
      end else begin
        next_port_role = `UHC_ROLE_SDP;
      end
    end
  end

  // Registered outputs; everything is idle and disconnected in reset.
  always @(posedge clk) begin
    if (reset) begin
      host_path_en <= 1'b0;
      dp_dm_short <= 1'b0;
      dcp_signature <= `UHC_SIG_NONE;
      cdp_primary_en <= 1'b0;
      cdp_secondary_en <= 1'b0;
      port_role <= `UHC_ROLE_IDLE;
    end else begin
      host_path_en <= next_host_path_en;
      dp_dm_short <= next_dp_dm_short;
      dcp_signature <= next_dcp_signature;
      cdp_primary_en <= next_cdp_primary_en;
      cdp_secondary_en <= next_cdp_secondary_en;
      port_role <= next_port_role;
    end
  end

  // Limitation: the mid-level select used for the manual charging mode is
  // not seen here, because the select arrives as a clean logic level. A
  // system that wants that mode must arrange it before power-up.

endmodule // uhc_ctrl

// [verif/uhc_ctrl_properties.sv]
`timescale 1ns/10ps
`include "uhc_consts.vh"
// Port checker; PULSE follows the interrupt length the bench chose.
module uhc_props #(
  parameter [31:0] PULSE = 20
) (
  input wire clk,
  input wire reset,
  input wire system_awake_sel,
  input wire charge_type_sel,
  input wire dev_cdp_request,
  input wire int_oe,
  input wire host_path_en,
  input wire dp_dm_short,
  input wire [1:0] dcp_signature,
  input wire [2:0] port_role
);
  reg prev;
  reg [7:0] n;
  // Cycles since the select moved; saturates so a long idle never wraps.
  always @(posedge clk) begin
    prev <= system_awake_sel;
    if (reset) n <= 8'hFF;
    else if (system_awake_sel != prev) n <= 8'h00;
    else if (n != 8'hFF) n <= n + 8'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  //////////
  AST_INT_RISE: assert property ($changed(system_awake_sel) |=> int_oe)
    else $error("irq missing");
  AST_INT_SPAN: assert property (n < PULSE - 1 |-> int_oe)
    else $error("irq short");
  AST_INT_END: assert property (n == PULSE + 1 |-> !int_oe)
    else $error("irq long");
  AST_SLEEP: assert property (!system_awake_sel [*3] |-> port_role <= `UHC_ROLE_PASS)
    else $error("sleep role");
  AST_SDP: assert property (system_awake_sel && !charge_type_sel |=>
    port_role == `UHC_ROLE_SDP) else $error("sdp role");
  AST_CDP: assert property (system_awake_sel && charge_type_sel |=>
    port_role == ($past(dev_cdp_request) ? `UHC_ROLE_CDP : `UHC_ROLE_SDP))
    else $error("cdp role");
  AST_BC: assert property (dp_dm_short |-> !host_path_en && dcp_signature == `UHC_SIG_BC)
    else $error("short with data");
  AST_CDP_DATA: assert property (port_role == `UHC_ROLE_CDP |-> host_path_en)
    else $error("cdp no data");
  cover property ($rose(int_oe));
  cover property (dp_dm_short);
  cover property (port_role == `UHC_ROLE_PASS);
endmodule // uhc_props
bind uhc_ctrl uhc_props #(.PULSE(INT_PULSE_CYC)) u_props (.*);

// [verif/uhc_dev_model.sv]
`timescale 1ns/10ps
// Attached device; kind 0 BC phone, 1 vendor phone, 2 mouse, 3 CDP aware.
module uhc_dev_model (
  input wire clk,
  input wire plug,
  input wire [1:0] kind,
  input wire pri_en,
  input wire sec_en,
  output wire load,
  output wire lfs,
  output wire hid,
  output wire vend,
  output wire cdp,
  output reg pri_done,
  output reg sec_done
);
  assign load = plug;
  assign lfs = plug && kind == 2'h2;
  assign hid = lfs;
  assign vend = plug && kind == 2'h1;
  assign cdp = plug && kind == 2'h3;
  // Detection steps finish one cycle after the host opens them and stay done
  // until the device leaves, as a real device keeps its detection result.
  always @(posedge clk) begin
    pri_done <= cdp && (pri_done || pri_en);
    sec_done <= cdp && (sec_done || sec_en);
  end
endmodule // uhc_dev_model

// [verif/test_uhc_ctrl.sv]
`timescale 1ns/10ps
`include "uhc_consts.vh"
module test_uhc_ctrl;
  reg clk, reset, aw, ct, plug;
  reg [1:0] kind;
  wire ld, lfs, hid, vs, cr, pd, sd, io, ioe, hp, sh, pe, se;
  wire [1:0] sig;
  wire [2:0] role;
  integer bad_count, checks_done, cyc, k;
  uhc_ctrl #(.INT_PULSE_CYC(32'h14), .HOLDOFF_CYC(32'hA)) u_dut (.clk(clk), .reset(reset),
    .system_awake_sel(aw), .charge_type_sel(ct), .load_sensed(ld), .dev_low_full_speed(lfs),
    .dev_hid_class(hid), .dev_vendor_sig(vs), .dev_cdp_request(cr), .primary_det_done(pd),
    .secondary_det_done(sd), .int_out(io), .int_oe(ioe), .host_path_en(hp), .dp_dm_short(sh),
    .dcp_signature(sig), .cdp_primary_en(pe), .cdp_secondary_en(se), .port_role(role));
  uhc_dev_model u_dev (.clk(clk), .plug(plug), .kind(kind), .pri_en(pe), .sec_en(se),
    .load(ld), .lfs(lfs), .hid(hid), .vend(vs), .cdp(cr), .pri_done(pd), .sec_done(sd));
  task chk(input [7:0] seen, input [7:0] exp, input [63:0] what);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("BAD %0s exp %0h saw %0h", what, exp, seen);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task summarize;
    begin
      $display("checks %0d bad %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // A second edge mid-pulse must stretch the pulse past its first end.
  task t_irq;
    begin
      tick(1); aw <= 1'b1;
      tick(2); #1 chk(ioe, 1, "oe");
      chk(io, 1, "lvl");
      chk(role, `UHC_ROLE_SDP, "sdp");
      tick(8); aw <= 1'b0;
      tick(18); #1 chk(ioe, 1, "ext");
      tick(7); #1 chk(ioe, 0, "end");
    end
  endtask
  // Awake with CDP select, then sleep with a mouse kept on the host.
  task t_s0;
    begin
      tick(1); aw <= 1'b1; ct <= 1'b1; plug <= 1'b1; kind <= 2'h3;
      tick(3); #1 chk(role, `UHC_ROLE_CDP, "cdp");
      chk(hp, 1, "cdpdata");
      chk(pe, 0, "pri");
      chk(se, 1, "sec");
      tick(1); kind <= 2'h2;
      tick(3); #1 chk(role, `UHC_ROLE_SDP, "sdp2");
      tick(1); aw <= 1'b0;
      tick(1030); #1 chk(role, `UHC_ROLE_PASS, "pass");
      chk(hp, 1, "passdata");
    end
  endtask
  // Sleep charging picks the BC short, then the vendor signature; a replug
  // inside the hold-off must wait for it before the attach debounce starts.
  task t_dcp;
    for (k = 0; k < 2; k = k + 1) begin
      tick(1); plug <= 1'b0;
      tick(2); plug <= 1'b1; kind <= k[1:0];
      tick(1008); #1 chk(role, `UHC_ROLE_IDLE, "hold");
      tick(10); #1 chk(role, `UHC_ROLE_DCP, "dcp");
      chk(sh, k == 0, "short");
      chk(sig, (k == 0) ? `UHC_SIG_BC : `UHC_SIG_VENDOR, "sig");
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Guard against a hang; the whole run needs about 3100 cycles.
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      summarize;
    end
  end
  initial begin
    bad_count = 0; checks_done = 0; cyc = 0;
    // select kept at clean logic levels
    reset = 1'b1; aw = 1'b0; ct = 1'b0; plug = 1'b0; kind = 2'h0;
    tick(6); reset <= 1'b0;
    t_irq;
    t_s0;
    t_dcp;
    summarize;
  end
endmodule // test_uhc_ctrl
